//--- hdl/rms_results_regs.vh
// register indices, field positions and timing constants of the rms result bank
`ifndef RMS_RESULTS_REGS_VH
`define RMS_RESULTS_REGS_VH

// register indices; byte address is four times the index
`define IDX_MEAS_RMS_BACKUP 10'h0F8
`define IDX_INST_MEAS_RMS 10'h10F
`define IDX_INST_FUND_VOLTAGE_RMS 10'h112
`define IDX_INST_FUND_CURRENT_RMS 10'h113
`define IDX_AVG_MEAS_RMS 10'h117
`define IDX_AVG_TOTAL_VOLTAGE_RMS 10'h11B
`define IDX_AVG_TOTAL_CURRENT_RMS 10'h11C
`define IDX_AVG_FUND_VOLTAGE_RMS 10'h121
`define IDX_AVG_FUND_CURRENT_RMS 10'h122
`define IDX_CTRL 10'h130
`define IDX_STATUS 10'h131

// number of result words
`define RESULT_COUNT 9

// control register fields
`define CTRL_SLOW_CLK_BIT 0
`define CTRL_CURRENT_B_BIT 1
`define CTRL_MEAS_CURRENT_BIT 2
`define CTRL_RESET 32'h0000_0000
`define CTRL_MASK 32'h0000_0007

// status register fields
`define STAT_INST_SETTLED_BIT 0
`define STAT_AVG_SETTLED_BIT 1

// result reset value
`define RESULT_RESET 32'h0000_0000

// system clock rate in kHz
`define CLK_SYS_KHZ 40000

// times in milliseconds
`define INST_FAST_REFRESH_MS 160
`define INST_FAST_SETTLE_MS 500
`define INST_SLOW_REFRESH_MS 640
`define INST_SLOW_SETTLE_MS 2000
`define AVG_FAST_REFRESH_MS 1280
`define AVG_FAST_SETTLE_MS 3000
`define AVG_SLOW_REFRESH_MS 5120
`define AVG_SLOW_SETTLE_MS 12000

// same times in system clock cycles
`define INST_FAST_REFRESH_CYC (`INST_FAST_REFRESH_MS * `CLK_SYS_KHZ)
`define INST_FAST_SETTLE_CYC (`INST_FAST_SETTLE_MS * `CLK_SYS_KHZ)
`define INST_SLOW_REFRESH_CYC (`INST_SLOW_REFRESH_MS * `CLK_SYS_KHZ)
`define INST_SLOW_SETTLE_CYC (`INST_SLOW_SETTLE_MS * `CLK_SYS_KHZ)
`define AVG_FAST_REFRESH_CYC (`AVG_FAST_REFRESH_MS * `CLK_SYS_KHZ)
`define AVG_FAST_SETTLE_CYC (`AVG_FAST_SETTLE_MS * `CLK_SYS_KHZ)
`define AVG_SLOW_REFRESH_CYC (`AVG_SLOW_REFRESH_MS * `CLK_SYS_KHZ)
`define AVG_SLOW_SETTLE_CYC (`AVG_SLOW_SETTLE_MS * `CLK_SYS_KHZ)

`endif

//--- hdl/refresh_timer.v
// periodic refresh tick and settle indication for one group of results
`timescale 1ns/1ps

module refresh_timer
(
    // clock and reset
    input wire clk_sys,
    input wire sys_rst,
    input wire ce,
    // control
    input wire restart,
    input wire [31:0] period_cyc,
    input wire [31:0] settle_cyc,
    // status
    output reg tick,
    output reg settled
);

    reg [31:0] period_cnt_reg;
    reg [31:0] settle_cnt_reg;

    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            period_cnt_reg <= 32'h0000_0000;
            settle_cnt_reg <= 32'h0000_0000;
            tick <= 1'b0;
            settled <= 1'b0;
        end
        else if (ce)
        begin
            tick <= 1'b0;
            if (restart)
            begin
                // a new input starts both the refresh phase and the settle wait
                period_cnt_reg <= 32'h0000_0000;
                settle_cnt_reg <= 32'h0000_0000;
                settled <= 1'b0;
            end
            else
            begin
                if (period_cnt_reg >= period_cyc - 32'h0000_0001)
                begin
                    period_cnt_reg <= 32'h0000_0000;
                    tick <= 1'b1;
                end
                else
                begin
                    period_cnt_reg <= period_cnt_reg + 32'h0000_0001;
                end
                if (!settled)
                begin
                    if (settle_cnt_reg >= settle_cyc - 32'h0000_0001)
                    begin
                        settled <= 1'b1;
                    end
                    else
                    begin
                        settle_cnt_reg <= settle_cnt_reg + 32'h0000_0001;
                    end
                end
            end
        end
    end

endmodule

//--- hdl/rms_result_registers.v
// rms result register bank with apb slave, refresh timing and input selection
// How it works
// R1: with the fast metering clock each instantaneous result refreshes every 160 ms, settled 500 ms after an input change.
// R2: with the slow metering clock each instantaneous result refreshes every 640 ms and settles within 2000 ms.
// R3: with the fast metering clock each averaged result refreshes every 1.28 s and settles within 3 s.
// R4: with the slow metering clock each averaged result refreshes every 5.12 s and settles within 12 s.
// R5: when the measurement channel handles a current input, its instantaneous rms is mirrored into the backup word the host reads.
// R6: the instantaneous fundamental current word takes input a when the current channel uses a, else input b.
// R7: the averaged total current word takes input a when the current channel uses a, else input b.
// R8: the averaged fundamental current word takes input a when the current channel uses a, else input b.
// R9: the averaged total voltage rms is a 32-bit two's-complement word at its own index.
// R10: the averaged measurement-channel rms has its own 32-bit word.
// R11: the averaged fundamental voltage rms has its own 32-bit word.
// R12: the instantaneous fundamental voltage rms has its own 32-bit word.
// R13: the instantaneous measurement-channel rms has its own 32-bit word.
// R14: each result word keeps its value between refreshes and changes only at its refresh instant or on a host write to it.
`timescale 1ns/1ps
`include "rms_results_regs.vh"

module rms_result_registers
#(
    // clk_sys cycles per millisecond; one knob scales every interval alike
    parameter [31:0] CYC_PER_MS = `CLK_SYS_KHZ
)
(
    // clock, reset, enable
    input wire clk_sys,
    input wire sys_rst,
    input wire ce,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,
    // instantaneous results from the metering datapath
    input wire [31:0] inst_meas_sample,
    input wire [31:0] inst_fund_voltage_sample,
    input wire [31:0] inst_fund_current_a_sample,
    input wire [31:0] inst_fund_current_b_sample,
    // averaged results from the metering datapath
    input wire [31:0] avg_meas_sample,
    input wire [31:0] avg_total_voltage_sample,
    input wire [31:0] avg_total_current_a_sample,
    input wire [31:0] avg_total_current_b_sample,
    input wire [31:0] avg_fund_voltage_sample,
    input wire [31:0] avg_fund_current_a_sample,
    input wire [31:0] avg_fund_current_b_sample,
    // mode and refresh outputs to the datapath
    output wire metering_clock_slow,
    output wire current_input_b_sel,
    output wire meas_current_mode,
    output wire inst_refresh,
    output wire avg_refresh
);

    localparam [3:0] E_BACKUP = 4'h0;
    localparam [3:0] E_INST_MEAS = 4'h1;
    localparam [3:0] E_INST_FV = 4'h2;
    localparam [3:0] E_INST_FC = 4'h3;
    localparam [3:0] E_AVG_MEAS = 4'h4;
    localparam [3:0] E_AVG_TV = 4'h5;
    localparam [3:0] E_AVG_TC = 4'h6;
    localparam [3:0] E_AVG_FV = 4'h7;
    localparam [3:0] E_AVG_FC = 4'h8;

    localparam [31:0] INST_FAST_REFRESH_CYC = `INST_FAST_REFRESH_MS * CYC_PER_MS;
    localparam [31:0] INST_FAST_SETTLE_CYC = `INST_FAST_SETTLE_MS * CYC_PER_MS;
    localparam [31:0] INST_SLOW_REFRESH_CYC = `INST_SLOW_REFRESH_MS * CYC_PER_MS;
    localparam [31:0] INST_SLOW_SETTLE_CYC = `INST_SLOW_SETTLE_MS * CYC_PER_MS;
    localparam [31:0] AVG_FAST_REFRESH_CYC = `AVG_FAST_REFRESH_MS * CYC_PER_MS;
    localparam [31:0] AVG_FAST_SETTLE_CYC = `AVG_FAST_SETTLE_MS * CYC_PER_MS;
    localparam [31:0] AVG_SLOW_REFRESH_CYC = `AVG_SLOW_REFRESH_MS * CYC_PER_MS;
    localparam [31:0] AVG_SLOW_SETTLE_CYC = `AVG_SLOW_SETTLE_MS * CYC_PER_MS;

    // index of each result word in the map
    function [9:0] entry_index;
        input [3:0] entry;
        begin
            case (entry)
                E_BACKUP: entry_index = `IDX_MEAS_RMS_BACKUP;
                E_INST_MEAS: entry_index = `IDX_INST_MEAS_RMS; // [R13]
                E_INST_FV: entry_index = `IDX_INST_FUND_VOLTAGE_RMS; // [R12]
                E_INST_FC: entry_index = `IDX_INST_FUND_CURRENT_RMS;
                E_AVG_MEAS: entry_index = `IDX_AVG_MEAS_RMS; // [R10]
                E_AVG_TV: entry_index = `IDX_AVG_TOTAL_VOLTAGE_RMS; // [R9]
                E_AVG_TC: entry_index = `IDX_AVG_TOTAL_CURRENT_RMS;
                E_AVG_FV: entry_index = `IDX_AVG_FUND_VOLTAGE_RMS; // [R11]
                E_AVG_FC: entry_index = `IDX_AVG_FUND_CURRENT_RMS;
                default: entry_index = 10'h3FF;
            endcase
        end
    endfunction

    reg [31:0] ctrl_reg;
    reg [31:0] ctrl_prev_reg;
    reg setup_seen_reg;
    reg [31:0] result_reg [0:`RESULT_COUNT-1];

    wire [9:0] word_index;
    wire setup_phase;
    wire access_write;
    wire ctrl_hit;
    wire status_hit;
    wire mode_change;
    wire inst_tick;
    wire avg_tick;
    wire inst_settled;
    wire avg_settled;
    wire [31:0] inst_period;
    wire [31:0] inst_settle;
    wire [31:0] avg_period;
    wire [31:0] avg_settle;
    wire [31:0] status_word;
    wire [31:0] sel_inst_fc;
    wire [31:0] sel_avg_tc;
    wire [31:0] sel_avg_fc;
    wire [`RESULT_COUNT-1:0] hit;
    wire [`RESULT_COUNT-1:0] refresh;
    wire [31:0] source [0:`RESULT_COUNT-1];

    reg [31:0] read_mux;
    reg any_hit;
    integer k;

    assign word_index = paddr[11:2];
    // a setup missed while frozen is taken in the access phase, one wait state later
    assign setup_phase = psel & ~setup_seen_reg;
    // a frozen block holds the host off instead of dropping the access
    assign pready = ce & (setup_seen_reg | ~penable);
    assign access_write = psel & penable & pwrite & pready;
    assign ctrl_hit = (word_index == `IDX_CTRL);
    assign status_hit = (word_index == `IDX_STATUS);

    assign metering_clock_slow = ctrl_reg[`CTRL_SLOW_CLK_BIT];
    assign current_input_b_sel = ctrl_reg[`CTRL_CURRENT_B_BIT];
    assign meas_current_mode = ctrl_reg[`CTRL_MEAS_CURRENT_BIT];

    // any change of clock rate or input routing counts as a new input
    assign mode_change = (ctrl_reg != ctrl_prev_reg);

    assign inst_period = metering_clock_slow ? INST_SLOW_REFRESH_CYC // [R2]
                                             : INST_FAST_REFRESH_CYC; // [R1]
    assign inst_settle = metering_clock_slow ? INST_SLOW_SETTLE_CYC // [R2]
                                             : INST_FAST_SETTLE_CYC; // [R1]
    assign avg_period = metering_clock_slow ? AVG_SLOW_REFRESH_CYC // [R4]
                                            : AVG_FAST_REFRESH_CYC; // [R3]
    assign avg_settle = metering_clock_slow ? AVG_SLOW_SETTLE_CYC // [R4]
                                            : AVG_FAST_SETTLE_CYC; // [R3]

    refresh_timer inst_timer
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ce(ce),
        .restart(mode_change),
        .period_cyc(inst_period),
        .settle_cyc(inst_settle),
        .tick(inst_tick),
        .settled(inst_settled)
    );

    refresh_timer avg_timer
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ce(ce),
        .restart(mode_change),
        .period_cyc(avg_period),
        .settle_cyc(avg_settle),
        .tick(avg_tick),
        .settled(avg_settled)
    );

    assign inst_refresh = inst_tick;
    assign avg_refresh = avg_tick;

    assign status_word = {30'h0000_0000, avg_settled, inst_settled};

    assign sel_inst_fc = current_input_b_sel ? inst_fund_current_b_sample
                                             : inst_fund_current_a_sample; // [R6]
    assign sel_avg_tc = current_input_b_sel ? avg_total_current_b_sample
                                            : avg_total_current_a_sample; // [R7]
    assign sel_avg_fc = current_input_b_sel ? avg_fund_current_b_sample
                                            : avg_fund_current_a_sample; // [R8]

    // backup follows the instantaneous measurement word, so it takes the same sample
    assign source[E_BACKUP] = inst_meas_sample; // [R5]
    assign source[E_INST_MEAS] = inst_meas_sample;
    assign source[E_INST_FV] = inst_fund_voltage_sample;
    assign source[E_INST_FC] = sel_inst_fc;
    assign source[E_AVG_MEAS] = avg_meas_sample;
    assign source[E_AVG_TV] = avg_total_voltage_sample;
    assign source[E_AVG_TC] = sel_avg_tc;
    assign source[E_AVG_FV] = avg_fund_voltage_sample;
    assign source[E_AVG_FC] = sel_avg_fc;

    assign refresh[E_BACKUP] = inst_tick & meas_current_mode; // [R5]
    assign refresh[E_INST_MEAS] = inst_tick;
    assign refresh[E_INST_FV] = inst_tick;
    assign refresh[E_INST_FC] = inst_tick;
    assign refresh[E_AVG_MEAS] = avg_tick;
    assign refresh[E_AVG_TV] = avg_tick;
    assign refresh[E_AVG_TC] = avg_tick;
    assign refresh[E_AVG_FV] = avg_tick;
    assign refresh[E_AVG_FC] = avg_tick;

    genvar i;
    generate
        for (i = 0; i < `RESULT_COUNT; i = i + 1)
        begin : entry
            assign hit[i] = (word_index == entry_index(i[3:0]));

            always @(posedge clk_sys or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    result_reg[i] <= `RESULT_RESET;
                end
                else if (ce)
                begin
                    // a refresh in the same cycle as a host write wins
                    if (refresh[i])
                    begin
                        result_reg[i] <= source[i]; // [R14]
                    end
                    else if (access_write && hit[i])
                    begin
                        result_reg[i] <= pwdata;
                    end
                end
            end
        end
    endgenerate

    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_reg <= `CTRL_RESET;
            ctrl_prev_reg <= `CTRL_RESET;
        end
        else if (ce)
        begin
            ctrl_prev_reg <= ctrl_reg;
            if (access_write && ctrl_hit)
            begin
                ctrl_reg <= pwdata & `CTRL_MASK;
            end
        end
    end

    always @*
    begin
        read_mux = 32'h0000_0000;
        any_hit = ctrl_hit | status_hit;
        if (ctrl_hit)
        begin
            read_mux = ctrl_reg;
        end
        else if (status_hit)
        begin
            read_mux = status_word;
        end
        for (k = 0; k < `RESULT_COUNT; k = k + 1)
        begin
            if (hit[k])
            begin
                read_mux = result_reg[k];
                any_hit = 1'b1;
            end
        end
    end

    // read word and error are captured in the setup cycle and shown in the access phase
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            setup_seen_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (setup_phase)
            begin
                setup_seen_reg <= 1'b1;
                prdata <= pwrite ? 32'h0000_0000 : read_mux;
                // status is read-only, so a write to it is an error too
                pslverr <= ~any_hit | (pwrite & status_hit);
            end
            else
            begin
                setup_seen_reg <= 1'b0;
            end
        end
    end

endmodule

//--- bench/rms_result_checker_props.sv
// assertion checker for the rms result register bank
`timescale 1ns/1ps
`include "rms_results_regs.vh"

module rms_result_checker
#(
    parameter [31:0] INST_FAST_REFRESH_CYC = 32'h10,
    parameter [31:0] INST_SLOW_REFRESH_CYC = 32'h40,
    parameter [31:0] AVG_FAST_REFRESH_CYC = 32'h80,
    parameter [31:0] AVG_SLOW_REFRESH_CYC = 32'h200
)
(
    // clock, reset, enable
    input wire clk_sys,
    input wire sys_rst,
    input wire ce,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    // modes and refresh pulses
    input wire metering_clock_slow,
    input wire current_input_b_sel,
    input wire meas_current_mode,
    input wire inst_refresh,
    input wire avg_refresh
);
    wire [2:0] mode = {meas_current_mode, current_input_b_sel, metering_clock_slow};
    wire [9:0] idx = paddr[11:2];
    wire mapped = idx inside {`IDX_MEAS_RMS_BACKUP, `IDX_INST_MEAS_RMS,
        `IDX_INST_FUND_VOLTAGE_RMS, `IDX_INST_FUND_CURRENT_RMS, `IDX_AVG_MEAS_RMS,
        `IDX_AVG_TOTAL_VOLTAGE_RMS, `IDX_AVG_TOTAL_CURRENT_RMS, `IDX_AVG_FUND_VOLTAGE_RMS,
        `IDX_AVG_FUND_CURRENT_RMS, `IDX_CTRL, `IDX_STATUS};
    reg [2:0] mode_reg;
    reg [3:0] chg_reg;
    reg [31:0] i_gap_reg;
    reg [31:0] a_gap_reg;
    reg i_ok_reg;
    reg a_ok_reg;
    // timers restart a few cycles after a mode change, so that interval is not measured
    wire chg = (|chg_reg) || (mode != mode_reg);

    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mode_reg <= 3'h0;
            chg_reg <= 4'h0;
            i_gap_reg <= 32'h0;
            a_gap_reg <= 32'h0;
            i_ok_reg <= 1'b0;
            a_ok_reg <= 1'b0;
        end
        else
        begin
            mode_reg <= mode;
            chg_reg <= {chg_reg[2:0], mode != mode_reg};
            if (ce)
            begin
                i_gap_reg <= inst_refresh ? 32'h0 : i_gap_reg + 32'h1;
                a_gap_reg <= avg_refresh ? 32'h0 : a_gap_reg + 32'h1;
                if (inst_refresh)
                    i_ok_reg <= !chg;
                if (avg_refresh)
                    a_ok_reg <= !chg;
            end
            if (chg)
            begin
                i_ok_reg <= 1'b0;
                a_ok_reg <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence ctrl_write_s;
        psel && penable && pwrite && pready && idx == `IDX_CTRL;
    endsequence
    sequence inst_tick_s;
        inst_refresh && ce && i_ok_reg && !chg;
    endsequence
    sequence avg_tick_s;
        avg_refresh && ce && a_ok_reg && !chg;
    endsequence

    a_inst_fast_period: assert property (
        inst_tick_s |-> metering_clock_slow || i_gap_reg == INST_FAST_REFRESH_CYC - 32'h1)
        else $error("fast instantaneous refresh period wrong");
    a_inst_slow_period: assert property (
        inst_tick_s |-> !metering_clock_slow || i_gap_reg == INST_SLOW_REFRESH_CYC - 32'h1)
        else $error("slow instantaneous refresh period wrong");
    a_avg_fast_period: assert property (
        avg_tick_s |-> metering_clock_slow || a_gap_reg == AVG_FAST_REFRESH_CYC - 32'h1)
        else $error("fast averaged refresh period wrong");
    a_avg_slow_period: assert property (
        avg_tick_s |-> !metering_clock_slow || a_gap_reg == AVG_SLOW_REFRESH_CYC - 32'h1)
        else $error("slow averaged refresh period wrong");
    a_tick_one_cycle: assert property ((inst_refresh && ce ##1 ce) |-> !inst_refresh)
        else $error("instantaneous refresh pulse longer than a cycle");
    a_ctrl_input_sel: assert property (
        ctrl_write_s |=> current_input_b_sel == $past(pwdata[1]))
        else $error("current input select not taken from write");
    a_ctrl_meas_mode: assert property (
        ctrl_write_s |=> meas_current_mode == $past(pwdata[2]))
        else $error("measurement mode not taken from write");
    a_unmapped_err: assert property (
        psel && penable && pready && !pwrite |-> pslverr == !mapped)
        else $error("error response does not match address map");
    a_read_word_hold: assert property (psel && penable && pready |=> $stable(prdata))
        else $error("read data changed outside a setup edge");
endmodule

bind rms_result_registers rms_result_checker #(
    .INST_FAST_REFRESH_CYC(INST_FAST_REFRESH_CYC),
    .INST_SLOW_REFRESH_CYC(INST_SLOW_REFRESH_CYC),
    .AVG_FAST_REFRESH_CYC(AVG_FAST_REFRESH_CYC),
    .AVG_SLOW_REFRESH_CYC(AVG_SLOW_REFRESH_CYC)
) chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .metering_clock_slow(metering_clock_slow),
    .current_input_b_sel(current_input_b_sel), .meas_current_mode(meas_current_mode),
    .inst_refresh(inst_refresh), .avg_refresh(avg_refresh)
);

//--- bench/tb_rms_result_registers.sv
// self-checking testbench for the rms result register bank
`timescale 1ns/1ps
`include "rms_results_regs.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module tb_rms_result_registers;
    logic clk_sys = 0, sys_rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, bk = 32'h0, old, lf = 32'h9FE58A6B;
    logic [31:0] s [0:10] = '{default: 32'h0};
    logic [2:0] cur = 3'h0;
    logic [2:0] modes [4] = '{3'h0, 3'h5, 3'h2, 3'h3};
    logic [44:0] exp_q [$];
    logic [44:0] ex;
    wire pready, pslverr, inst_refresh, avg_refresh;
    wire [2:0] mode_pins;
    wire [31:0] prdata;
    int error_cnt = 0, n_checks = 0, cyc = 0;

    always #12.5 clk_sys = ~clk_sys;

    // one cycle per millisecond keeps every interval in its true proportion
    rms_result_registers #(.CYC_PER_MS(32'h1)) uut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .inst_meas_sample(s[0]), .inst_fund_voltage_sample(s[1]),
        .inst_fund_current_a_sample(s[2]), .inst_fund_current_b_sample(s[3]),
        .avg_meas_sample(s[4]), .avg_total_voltage_sample(s[5]),
        .avg_total_current_a_sample(s[6]), .avg_total_current_b_sample(s[7]),
        .avg_fund_voltage_sample(s[8]), .avg_fund_current_a_sample(s[9]),
        .avg_fund_current_b_sample(s[10]), .metering_clock_slow(mode_pins[0]),
        .current_input_b_sel(mode_pins[1]), .meas_current_mode(mode_pins[2]),
        .inst_refresh(inst_refresh), .avg_refresh(avg_refresh)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h0);
    endfunction

    // reads note {error, data} expected; the monitor compares it at completion
    task automatic apb(input logic w, input logic [9:0] i, input logic [32:0] d);
        @(posedge clk_sys);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= d[31:0];
        if (!w)
            exp_q.push_back({i, 2'b00, d});
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask

    task automatic rd_all;
        apb(0, `IDX_MEAS_RMS_BACKUP, {1'b0, bk});
        apb(0, `IDX_INST_MEAS_RMS, {1'b0, s[0]});
        apb(0, `IDX_INST_FUND_VOLTAGE_RMS, {1'b0, s[1]});
        apb(0, `IDX_INST_FUND_CURRENT_RMS, {1'b0, cur[1] ? s[3] : s[2]});
        apb(0, `IDX_AVG_MEAS_RMS, {1'b0, s[4]});
        apb(0, `IDX_AVG_TOTAL_VOLTAGE_RMS, {1'b0, s[5]});
        apb(0, `IDX_AVG_TOTAL_CURRENT_RMS, {1'b0, cur[1] ? s[7] : s[6]});
        apb(0, `IDX_AVG_FUND_VOLTAGE_RMS, {1'b0, s[8]});
        apb(0, `IDX_AVG_FUND_CURRENT_RMS, {1'b0, cur[1] ? s[10] : s[9]});
    endtask

    task automatic rnd(input int lo);
        @(posedge clk_sys);
        for (int j = lo; j < 11; j++)
        begin
            lf = lfsr(lf);
            s[j] <= lf;
            if (j == 0 && cur[2])
                bk = lf;
        end
    endtask

    // enable drops now and then so the timers must freeze, not count
    task automatic wait_tick(input logic avg);
        int n = 0;
        logic hit = 0;
        while (!hit)
        begin
            @(posedge clk_sys);
            hit = (avg ? avg_refresh : inst_refresh) && ce;
            n++;
            ce <= hit || (n % 7 != 3);
        end
    endtask

    task automatic end_of_test;
        if (error_cnt == 0 && n_checks > 0 && exp_q.size() == 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 50000)
        begin
            error_cnt++;
            end_of_test;
        end
        if (psel && penable && pready && !pwrite && exp_q.size() > 0)
        begin
            ex = exp_q.pop_front();
            `CHK($sformatf("read %h", ex[44:33]), ex[32:0], {pslverr, prdata})
            if (ex[44:35] == `IDX_CTRL)
                `CHK("mode pins", ex[2:0], mode_pins)
        end
    end

    initial
    begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 0;
        apb(0, `IDX_STATUS, 33'h0);
        rd_all;
        // a host write stands until the next refresh reloads the word
        apb(1, `IDX_INST_FUND_VOLTAGE_RMS, 33'h0_5A5A_0F0F);
        apb(0, `IDX_INST_FUND_VOLTAGE_RMS, 33'h0_5A5A_0F0F);
        apb(0, 10'h000, {1'b1, 32'h0});
        apb(0, 10'h110, {1'b1, 32'h0});
        apb(1, `IDX_STATUS, 33'h0);
        foreach (modes[k])
        begin
            cur = modes[k];
            apb(1, `IDX_CTRL, {30'h0, cur});
            apb(0, `IDX_CTRL, {30'h0, cur});
            rnd(0);
            // two averaged ticks, so the checker measures one full period per mode
            repeat (2) wait_tick(1);
            wait_tick(0);
            rd_all;
            apb(0, `IDX_STATUS, 33'h1);
            old = s[5];
            // averaged inputs move, but the word must not until its next refresh
            rnd(4);
            apb(0, `IDX_AVG_TOTAL_VOLTAGE_RMS, {1'b0, old});
        end
        repeat (1300) @(posedge clk_sys);
        apb(0, `IDX_STATUS, 33'h3);
        repeat (2) @(posedge clk_sys);
        end_of_test;
    end
endmodule
